//--- logic/irq_init_pkg.sv
package irq_init_pkg;
  // widths and counts
  localparam int DATA_W = 8;
  localparam int ADDR_W = 10;
  localparam int NUM_IN = 8;
  localparam int NUM_CTRL = 2;
  localparam int PRI = 0;
  localparam int SEC = 1;
  // port addresses: primary even/odd, secondary even/odd
  localparam logic [ADDR_W-1:0] PRI_EVEN_ADDR = 10'h020;
  localparam logic [ADDR_W-1:0] PRI_ODD_ADDR = 10'h021;
  localparam logic [ADDR_W-1:0] SEC_EVEN_ADDR = 10'h0A0;
  localparam logic [ADDR_W-1:0] SEC_ODD_ADDR = 10'h0A1;
  // first init word fields
  localparam int INIT_SEL_BIT = 4;
  localparam int LEVEL_BIT = 3;
  localparam int SINGLE_BIT = 1;
  // command word on even port: bits 4:3 select, bits 7:5 function
  localparam logic [1:0] CMD2_SEL = 2'h0;
  localparam logic [2:0] NS_EOI_CODE = 3'h1;
  // vector base field
  localparam int VEC_HI = 7;
  localparam int VEC_LO = 3;
  localparam int VEC_BASE_W = VEC_HI - VEC_LO + 1;
  // slave identity field width
  localparam int IDENT_W = 3;
  // mode option word fields
  localparam int NEST_BIT = 4;
  localparam int AUTO_END_OF_INTERRUPT_BIT = 1;
  // reset values
  localparam logic [DATA_W-1:0] MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
  localparam logic [VEC_BASE_W-1:0] VEC_RST = 5'h00;
  localparam logic [IDENT_W-1:0] IDENT_RST = 3'h0;
  // index returned when no request wins at acknowledge
  localparam logic [IDENT_W-1:0] SPURIOUS_IDX = 3'h7;

  // init sequencer states
  typedef enum logic [3:0] {
    SEQ_READY = 4'h1,
    SEQ_VEC = 4'h2,
    SEQ_CASC = 4'h4,
    SEQ_MODE = 4'h8
  } seq_state_t;

  // acknowledge sequence states
  typedef enum logic [1:0] {
    ACK_IDLE = 2'h1,
    ACK_SECOND = 2'h2
  } ack_state_t;
endpackage : irq_init_pkg

//--- logic/ctrl_cfg_if.sv
`timescale 1ns/1ps
interface ctrl_cfg_if;
  import irq_init_pkg::*;
  logic [VEC_BASE_W-1:0] vec_base; // upper vector bits
  logic [DATA_W-1:0] link_map; // cascade map (primary) or identity (secondary)
  logic nest_en; // multiple interrupts from same channel
  logic auto_end_of_interrupt_en; // automatic end of interrupt
  logic level_mode; // level triggered requests
  logic [DATA_W-1:0] mask; // per-input mask
  logic init_pulse; // first init word written
  logic eoi_pulse; // non-specific end of interrupt command
  modport regs (
    output vec_base, link_map, nest_en, auto_end_of_interrupt_en, level_mode, mask, init_pulse, eoi_pulse
  );
  modport core (
    input vec_base, link_map, nest_en, auto_end_of_interrupt_en, level_mode, mask, init_pulse, eoi_pulse
  );
endinterface : ctrl_cfg_if

//--- logic/ctrl_regs.sv
`timescale 1ns/1ps
module ctrl_regs
  import irq_init_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic wr_even_in, // write strobe to even port
  input wire logic wr_odd_in, // write strobe to odd port
  input wire logic [irq_init_pkg::DATA_W-1:0] wdata_in, // write data
  ctrl_cfg_if.regs cfg // configuration toward the core
);
  import irq_init_pkg::*;

  seq_state_t seq_q;
  logic single_q;
  logic init_w;
  logic odd_ready_w;

  // first init word recognised by its select bit
  assign init_w = wr_even_in && wdata_in[INIT_SEL_BIT];
  assign odd_ready_w = wr_odd_in && (seq_q == SEQ_READY);

  // init word sequencing
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq_q <= SEQ_READY;
    end else if (init_w) begin
      seq_q <= SEQ_VEC;
    end else if (wr_odd_in) begin
      case (seq_q)
        SEQ_VEC: seq_q <= single_q ? SEQ_MODE : SEQ_CASC;
        SEQ_CASC: seq_q <= SEQ_MODE;
        SEQ_MODE: seq_q <= SEQ_READY;
        SEQ_READY: seq_q <= SEQ_READY;
        default: seq_q <= SEQ_READY;
      endcase
    end
  end

  // first init word options
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      single_q <= 1'b0;
      cfg.level_mode <= 1'b0;
    end else if (init_w) begin
      single_q <= wdata_in[SINGLE_BIT];
      cfg.level_mode <= wdata_in[LEVEL_BIT];
    end
  end

  // vector base, upper five bits only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg.vec_base <= VEC_RST;
    end else if (wr_odd_in && seq_q == SEQ_VEC) begin
      cfg.vec_base <= wdata_in[VEC_HI:VEC_LO];
    end
  end

  // cascade map or slave identity word
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg.link_map <= BYTE_RST;
    end else if (wr_odd_in && seq_q == SEQ_CASC) begin
      cfg.link_map <= wdata_in;
    end
  end

  // mode option word
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg.nest_en <= 1'b0;
      cfg.auto_end_of_interrupt_en <= 1'b0;
    end else if (wr_odd_in && seq_q == SEQ_MODE) begin
      cfg.nest_en <= wdata_in[NEST_BIT];
      cfg.auto_end_of_interrupt_en <= wdata_in[AUTO_END_OF_INTERRUPT_BIT];
    end
  end

  // mask word, cleared by the first init word
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg.mask <= MASK_RST;
    end else if (init_w) begin
      cfg.mask <= MASK_RST;
    end else if (odd_ready_w) begin
      cfg.mask <= wdata_in;
    end
  end

  // command pulses
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg.init_pulse <= 1'b0;
      cfg.eoi_pulse <= 1'b0;
    end else begin
      cfg.init_pulse <= init_w;
      cfg.eoi_pulse <= wr_even_in && wdata_in[4:3] == CMD2_SEL && wdata_in[7:5] == NS_EOI_CODE;
    end
  end
endmodule : ctrl_regs

//--- logic/cascaded_irq_init_mask.sv
`timescale 1ns/1ps
// Function
// - each controller keeps vector bits 7:3 written and returns them as vector top
// - vector bits 2:0 come from the winning request input at acknowledge
// - primary and secondary hold independent vector bases, any values allowed
// - primary cascade map bit n marks a secondary on request input n
// - secondary identity bits 2:0 give the cascade address it answers
// - mode bit 4 lets the same channel interrupt again under fixed priority
// - mode bit 1 performs non-specific EOI at end of second acknowledge
// - eight-bit read/write mask word, bit n masks input n
// - masking one input leaves lower-priority requests eligible
// - writing the first init word clears the whole mask word
// - even-port write with bit 4 set is the first init word
// - primary lets secondary supply vector when winning input has a secondary
module cascaded_irq_init_mask
  import irq_init_pkg::*;
(
  input wire logic CLK_IN, // host bus clock
  input wire logic RESETN_IN, // async reset, active low
  input wire logic [irq_init_pkg::ADDR_W-1:0] ADDR_IN, // io address
  input wire logic IOW_IN, // io write strobe, one cycle
  input wire logic IOR_IN, // io read strobe, one cycle
  input wire logic [irq_init_pkg::DATA_W-1:0] DATA_IN, // write data
  input wire logic INTERRUPT_ACK_CYCLE_IN, // acknowledge cycle strobe, one cycle
  input wire logic [2*irq_init_pkg::NUM_IN-1:0] IRQ_IN, // request pins, 15:8 secondary
  output logic [irq_init_pkg::DATA_W-1:0] DATA_OUT, // read data or vector
  output logic DATA_OE_OUT, // DATA_OUT valid
  output logic INTR_OUT // interrupt request to cpu
);
  import irq_init_pkg::*;

  ctrl_cfg_if cif[NUM_CTRL] ();

  logic [2*NUM_IN-1:0] sync1_q;
  logic [2*NUM_IN-1:0] sync2_q;
  logic [DATA_W-1:0] req_w [NUM_CTRL];
  logic [DATA_W-1:0] prev_q [NUM_CTRL];
  logic [DATA_W-1:0] irr_q [NUM_CTRL];
  logic [DATA_W-1:0] isr_q [NUM_CTRL];
  logic [DATA_W-1:0] mask_w [NUM_CTRL];
  logic [3:0] win_w [NUM_CTRL];
  logic [DATA_W-1:0] set_isr_w [NUM_CTRL];
  logic [NUM_CTRL-1:0] auto_end_of_interrupt_w;
  logic [NUM_CTRL-1:0] wr_even_w;
  logic [NUM_CTRL-1:0] wr_odd_w;
  logic [NUM_CTRL-1:0] rd_sel_w;
  ack_state_t ack_q;
  logic from_sec_q;
  logic [IDENT_W-1:0] idx_q;
  logic pri_cas_w;
  logic sec_ans_w;
  logic first_ack_w;
  logic second_ack_w;

  // highest-priority eligible input, input 0 highest; bit 3 flags a winner
  function automatic logic [3:0] resolve(input logic [7:0] pend, input logic [7:0] serv,
                                         input logic nest);
    logic [3:0] res;
    logic stop;
    res = 4'h0;
    stop = 1'b0;
    for (int n = 0; n < NUM_IN; n++) begin
      if (!stop) begin
        if (pend[n] && (!serv[n] || nest)) begin
          res = {1'b1, 3'(n)};
          stop = 1'b1;
        end else if (serv[n]) begin
          stop = 1'b1;
        end
      end
    end
    return res;
  endfunction : resolve

  // address decode per controller
  assign wr_even_w[PRI] = IOW_IN && ADDR_IN == PRI_EVEN_ADDR;
  assign wr_odd_w[PRI] = IOW_IN && ADDR_IN == PRI_ODD_ADDR;
  assign wr_even_w[SEC] = IOW_IN && ADDR_IN == SEC_EVEN_ADDR;
  assign wr_odd_w[SEC] = IOW_IN && ADDR_IN == SEC_ODD_ADDR;
  assign rd_sel_w[PRI] = ADDR_IN == PRI_ODD_ADDR;
  assign rd_sel_w[SEC] = ADDR_IN == SEC_ODD_ADDR;

  // two-stage synchroniser on request pins
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= IRQ_IN;
      sync2_q <= sync1_q;
    end
  end

  // secondary inputs from pins
  assign req_w[SEC] = sync2_q[2*NUM_IN-1:NUM_IN];

  // primary inputs: a mapped position carries the secondary request
  generate
    for (genvar n = 0; n < NUM_IN; n++) begin : g_pri_in
      assign req_w[PRI][n] = cif[PRI].link_map[n] ? win_w[SEC][3] : sync2_q[n];
    end
  endgenerate

  // acknowledge decode and cascade choice
  assign first_ack_w = INTERRUPT_ACK_CYCLE_IN && ack_q == ACK_IDLE;
  assign second_ack_w = INTERRUPT_ACK_CYCLE_IN && ack_q == ACK_SECOND;
  assign pri_cas_w = win_w[PRI][3] && cif[PRI].link_map[win_w[PRI][2:0]];
  assign sec_ans_w = pri_cas_w && cif[SEC].link_map[IDENT_W-1:0] == win_w[PRI][2:0];

  generate
    for (genvar c = 0; c < NUM_CTRL; c++) begin : g_ctrl
      ctrl_regs u_regs (
        .clk_in(CLK_IN),
        .rst_n_in(RESETN_IN),
        .wr_even_in(wr_even_w[c]),
        .wr_odd_in(wr_odd_w[c]),
        .wdata_in(DATA_IN),
        .cfg(cif[c])
      );

      assign mask_w[c] = cif[c].mask;
      // mask gates only its own input
      assign win_w[c] = resolve(irr_q[c] & ~cif[c].mask, isr_q[c], cif[c].nest_en);
      assign auto_end_of_interrupt_w[c] = cif[c].auto_end_of_interrupt_en;

      // in-service bit taken by this controller at first acknowledge
      always_comb begin
        set_isr_w[c] = '0;
        if (first_ack_w && win_w[c][3] && (c == PRI || sec_ans_w)) begin
          set_isr_w[c][win_w[c][2:0]] = 1'b1;
        end
      end

      // request edge history
      always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          prev_q[c] <= '0;
        end else begin
          prev_q[c] <= req_w[c];
        end
      end

      // request register: new requests win over the acknowledge clear
      always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          irr_q[c] <= '0;
        end else if (cif[c].init_pulse) begin
          irr_q[c] <= '0;
        end else if (cif[c].level_mode) begin
          irr_q[c] <= req_w[c];
        end else begin
          irr_q[c] <= (irr_q[c] & ~set_isr_w[c]) | (req_w[c] & ~prev_q[c]);
        end
      end

      // in-service register with end of interrupt handling
      always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          isr_q[c] <= '0;
        end else if (cif[c].init_pulse) begin
          isr_q[c] <= '0;
        end else if (cif[c].eoi_pulse ||
                     (second_ack_w && auto_end_of_interrupt_w[c] && (c == PRI || from_sec_q))) begin
          isr_q[c] <= (isr_q[c] & (isr_q[c] - 8'h01)) | set_isr_w[c];
        end else begin
          isr_q[c] <= isr_q[c] | set_isr_w[c];
        end
      end
    end
  endgenerate

  // acknowledge sequence
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ack_q <= ACK_IDLE;
    end else begin
      case (ack_q)
        ACK_IDLE: ack_q <= INTERRUPT_ACK_CYCLE_IN ? ACK_SECOND : ACK_IDLE;
        ACK_SECOND: ack_q <= INTERRUPT_ACK_CYCLE_IN ? ACK_IDLE : ACK_SECOND;
        default: ack_q <= ACK_IDLE;
      endcase
    end
  end

  // winning index frozen at first acknowledge
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      from_sec_q <= 1'b0;
      idx_q <= SPURIOUS_IDX;
    end else if (first_ack_w) begin
      from_sec_q <= sec_ans_w && win_w[SEC][3];
      if (sec_ans_w && win_w[SEC][3]) begin
        idx_q <= win_w[SEC][2:0];
      end else if (win_w[PRI][3] && !pri_cas_w) begin
        idx_q <= win_w[PRI][2:0];
      end else begin
        idx_q <= SPURIOUS_IDX;
      end
    end
  end

  // data bus: vector on second acknowledge, mask on odd-port read
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      DATA_OUT <= BYTE_RST;
      DATA_OE_OUT <= 1'b0;
    end else if (second_ack_w) begin
      DATA_OE_OUT <= 1'b1;
      DATA_OUT <= from_sec_q ? {cif[SEC].vec_base, idx_q} : {cif[PRI].vec_base, idx_q};
    end else if (IOR_IN && rd_sel_w[PRI]) begin
      DATA_OE_OUT <= 1'b1;
      DATA_OUT <= mask_w[PRI];
    end else if (IOR_IN && rd_sel_w[SEC]) begin
      DATA_OE_OUT <= 1'b1;
      DATA_OUT <= mask_w[SEC];
    end else begin
      DATA_OE_OUT <= 1'b0;
      DATA_OUT <= BYTE_RST;
    end
  end

  // interrupt line follows the primary resolver
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      INTR_OUT <= 1'b0;
    end else begin
      INTR_OUT <= win_w[PRI][3];
    end
  end
endmodule : cascaded_irq_init_mask

//--- test/irq_chk.sv
`timescale 1ns/1ps
module irq_chk (
  input wire logic CLK_IN, // clock
  input wire logic RESETN_IN, // reset, active low
  input wire logic [irq_init_pkg::ADDR_W-1:0] ADDR_IN, // io address
  input wire logic IOW_IN, // write strobe
  input wire logic IOR_IN, // read strobe
  input wire logic [irq_init_pkg::DATA_W-1:0] DATA_IN, // write data
  input wire logic INTERRUPT_ACK_CYCLE_IN, // ack strobe
  input wire logic [2*irq_init_pkg::NUM_IN-1:0] IRQ_IN, // request pins
  input wire logic [irq_init_pkg::DATA_W-1:0] DATA_OUT, // read data or vector
  input wire logic DATA_OE_OUT, // data valid
  input wire logic INTR_OUT // cpu request
);
  import irq_init_pkg::*;
  logic ph_q;
  logic [1:0] st_q [NUM_CTRL];
  logic sg_q [NUM_CTRL];
  logic [DATA_W-1:0] mk_q [NUM_CTRL];
  logic [VEC_BASE_W-1:0] bs_q [NUM_CTRL];
  logic rd_p;
  logic init_p;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // primary mask read and primary init write
  assign rd_p = IOR_IN && !IOW_IN && !INTERRUPT_ACK_CYCLE_IN && ADDR_IN == PRI_ODD_ADDR;
  assign init_p = IOW_IN && ADDR_IN == PRI_EVEN_ADDR && DATA_IN[INIT_SEL_BIT];
  // ack phase, high when the next strobe is the second
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ph_q <= 1'b0;
    end else if (INTERRUPT_ACK_CYCLE_IN) begin
      ph_q <= !ph_q;
    end
  end
  // shadow of init step, base and mask per controller
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int c = 0; c < NUM_CTRL; c++) begin
        st_q[c] <= 2'h0;
        sg_q[c] <= 1'b0;
        mk_q[c] <= MASK_RST;
        bs_q[c] <= VEC_RST;
      end
    end else if (IOW_IN) begin
      for (int c = 0; c < NUM_CTRL; c++) begin
        if (ADDR_IN == (c == PRI ? PRI_EVEN_ADDR : SEC_EVEN_ADDR) && DATA_IN[INIT_SEL_BIT]) begin
          st_q[c] <= 2'h1;
          sg_q[c] <= DATA_IN[SINGLE_BIT];
          mk_q[c] <= MASK_RST;
        end else if (ADDR_IN == (c == PRI ? PRI_ODD_ADDR : SEC_ODD_ADDR)) begin
          mk_q[c] <= (st_q[c] == 2'h0) ? DATA_IN : mk_q[c];
          bs_q[c] <= (st_q[c] == 2'h1) ? DATA_IN[VEC_HI:VEC_LO] : bs_q[c];
          st_q[c] <= (st_q[c] == 2'h0) ? 2'h0 : (st_q[c] == 2'h1 && sg_q[c]) ? 2'h3 : st_q[c] + 2'h1;
        end
      end
    end
  end
  property p_rd_mask;
    rd_p |=> DATA_OE_OUT && DATA_OUT == $past(mk_q[PRI]);
  endproperty
  a_rd_mask: assert property (p_rd_mask)
    else $error("mask read wrong");
  property p_rd_even;
    IOR_IN && !INTERRUPT_ACK_CYCLE_IN && ADDR_IN == PRI_EVEN_ADDR |=> !DATA_OE_OUT;
  endproperty
  a_rd_even: assert property (p_rd_even)
    else $error("even port read answered");
  property p_init_clr;
    init_p ##[1:3] rd_p |=> DATA_OUT == MASK_RST;
  endproperty
  a_init_clr: assert property (p_init_clr)
    else $error("mask not cleared by init");
  property p_ack_oe;
    INTERRUPT_ACK_CYCLE_IN && ph_q |=> DATA_OE_OUT;
  endproperty
  a_ack_oe: assert property (p_ack_oe)
    else $error("no vector after second ack");
  property p_oe_cause;
    DATA_OE_OUT |-> $past(IOR_IN) || $past(INTERRUPT_ACK_CYCLE_IN);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("data valid without cause");
  property p_idle;
    !DATA_OE_OUT |-> DATA_OUT == BYTE_RST;
  endproperty
  a_idle: assert property (p_idle)
    else $error("data not zero while idle");
  property p_vec_hi;
    INTERRUPT_ACK_CYCLE_IN && ph_q |=> DATA_OUT[VEC_HI:VEC_LO] == bs_q[PRI] || DATA_OUT[VEC_HI:VEC_LO] == bs_q[SEC];
  endproperty
  a_vec_hi: assert property (p_vec_hi)
    else $error("vector top bits not a base");
  property p_wr_quiet;
    IOW_IN && !IOR_IN && !INTERRUPT_ACK_CYCLE_IN |=> !DATA_OE_OUT;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("write produced data");
  property p_intr_mask;
    mk_q[PRI] == 8'hFF && !IOW_IN |=> !INTR_OUT;
  endproperty
  a_intr_mask: assert property (p_intr_mask)
    else $error("request raised with all primary inputs masked");
endmodule : irq_chk

bind cascaded_irq_init_mask irq_chk u_chk (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
  .ADDR_IN(ADDR_IN), .IOW_IN(IOW_IN), .IOR_IN(IOR_IN), .DATA_IN(DATA_IN), .INTERRUPT_ACK_CYCLE_IN(INTERRUPT_ACK_CYCLE_IN),
  .IRQ_IN(IRQ_IN), .DATA_OUT(DATA_OUT), .DATA_OE_OUT(DATA_OE_OUT), .INTR_OUT(INTR_OUT));

//--- test/cpu_ack_model.sv
`timescale 1ns/1ps
module cpu_ack_model (
  input wire logic clk_in, // bus clock
  input wire logic rst_n_in, // reset, active low
  input wire logic go_in, // start one ack sequence
  input wire logic [3:0] gap_in, // extra idle cycles between pulses
  output logic interrupt_ack_cycle_out, // ack strobe
  output logic done_out // second pulse under way
);
  logic go_q;
  int cnt;
  // start request taken on the rising edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      go_q <= 1'b0;
    end else begin
      go_q <= go_in;
    end
  end
  // two pulses per sequence, launched off the falling edge
  always @(negedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interrupt_ack_cycle_out <= 1'b0;
      done_out <= 1'b0;
      cnt <= 0;
    end else if (cnt == 0 && go_q) begin
      interrupt_ack_cycle_out <= 1'b1;
      done_out <= 1'b0;
      cnt <= gap_in + 2;
    end else if (cnt == 1) begin
      interrupt_ack_cycle_out <= 1'b1;
      done_out <= 1'b1;
      cnt <= 0;
    end else begin
      interrupt_ack_cycle_out <= 1'b0;
      done_out <= 1'b0;
      cnt <= (cnt > 1) ? cnt - 1 : cnt;
    end
  end
endmodule : cpu_ack_model

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
  import irq_init_pkg::*;
  logic clk, rst_n, iow, ior, interrupt_ack_cycle, go, done, oe, intr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] din, dout, v;
  logic [2*NUM_IN-1:0] irq;
  logic [3:0] gap;
  int fails, checked, seed, base_m[NUM_CTRL], mask_m[NUM_CTRL];
  cascaded_irq_init_mask DUT (.CLK_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr), .IOW_IN(iow),
    .IOR_IN(ior), .DATA_IN(din), .INTERRUPT_ACK_CYCLE_IN(interrupt_ack_cycle), .IRQ_IN(irq), .DATA_OUT(dout),
    .DATA_OE_OUT(oe), .INTR_OUT(intr));
  cpu_ack_model cpu (.clk_in(clk), .rst_n_in(rst_n), .go_in(go), .gap_in(gap),
    .interrupt_ack_cycle_out(interrupt_ack_cycle), .done_out(done));
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog
  initial begin
    #50000;
    fails++;
    results();
  end
  function automatic int vec(input int c, input int k);
    return base_m[c] + k;
  endfunction : vec
  task chk(input string n, input int e, input logic [7:0] g);
    checked++;
    if (g !== e[7:0]) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e[7:0], g);
    end
  endtask : chk
  task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    din = d;
    iow = 1'b1;
    @(negedge clk);
    iow = 1'b0;
  endtask : wr
  task get(output logic [7:0] r);
    for (int i = 0; i < 3 && oe !== 1'b1; i++) @(negedge clk);
    r = (oe === 1'b1) ? dout : 8'hXX;
  endtask : get
  task rd(input logic [ADDR_W-1:0] a, output logic [7:0] r);
    @(negedge clk);
    addr = a;
    ior = 1'b1;
    @(negedge clk);
    ior = 1'b0;
    get(r);
  endtask : rd
  task ack(output logic [7:0] r);
    @(negedge clk);
    gap = 4'($random(seed)) & 4'h3;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge clk);
    @(negedge clk);
    get(r);
  endtask : ack
  task init(input int c, input logic [7:0] w1, input logic [7:0] b, input logic [7:0] id,
            input logic [7:0] md);
    wr(c == PRI ? PRI_EVEN_ADDR : SEC_EVEN_ADDR, w1);
    rd(c == PRI ? PRI_ODD_ADDR : SEC_ODD_ADDR, v);
    chk("mask_after_init", 0, v);
    wr(c == PRI ? PRI_ODD_ADDR : SEC_ODD_ADDR, b);
    wr(c == PRI ? PRI_ODD_ADDR : SEC_ODD_ADDR, id);
    wr(c == PRI ? PRI_ODD_ADDR : SEC_ODD_ADDR, md);
    base_m[c] = b & 8'hF8;
    mask_m[c] = 0;
  endtask : init
  task eoi(input int c);
    wr(c == PRI ? PRI_EVEN_ADDR : SEC_EVEN_ADDR, 8'h20);
  endtask : eoi
  task hit(input int k, input int e);
    @(negedge clk);
    irq[k] = 1'b1;
    for (int i = 0; i < 20 && intr !== 1'b1; i++) @(negedge clk);
    chk("intr", 1, {7'h00, intr});
    ack(v);
    irq[k] = 1'b0;
    chk("vector", e, v);
  endtask : hit
  task results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  // main sequence
  initial begin
    seed = 32'h3F3148FF;
    {rst_n, iow, ior, go} = 4'h0;
    addr = '0;
    din = '0;
    irq = '0;
    gap = 4'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    rd(PRI_ODD_ADDR, v);
    chk("mask_reset", 0, v);
    // even port read must not answer
    @(negedge clk);
    addr = PRI_EVEN_ADDR;
    ior = 1'b1;
    @(negedge clk);
    ior = 1'b0;
    chk("even_read_oe", 0, {7'h00, oe});
    init(PRI, 8'h11, 8'h08, 8'h04, 8'h01);
    init(SEC, 8'h11, 8'h70, 8'h02, 8'h01);
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      wr(i[0] ? SEC_ODD_ADDR : PRI_ODD_ADDR, v);
      mask_m[i % 2] = v;
      rd(i[0] ? SEC_ODD_ADDR : PRI_ODD_ADDR, v);
      chk("mask", mask_m[i % 2], v);
    end
    wr(SEC_ODD_ADDR, 8'h00);
    wr(PRI_ODD_ADDR, 8'h02);
    irq[1] = 1'b1;
    hit(4, vec(PRI, 4));
    eoi(PRI);
    wr(PRI_ODD_ADDR, 8'h00);
    hit(1, vec(PRI, 1));
    eoi(PRI);
    hit(13, vec(SEC, 5));
    eoi(SEC);
    eoi(PRI);
    wr(PRI_ODD_ADDR, 8'hFF);
    init(PRI, 8'h11, 8'h08, 8'h04, 8'h11);
    hit(13, vec(SEC, 5));
    hit(11, vec(SEC, 3));
    eoi(SEC);
    eoi(SEC);
    eoi(PRI);
    init(PRI, 8'h11, 8'h08, 8'h04, 8'h03);
    hit(4, vec(PRI, 4));
    hit(5, vec(PRI, 5));
    ack(v);
    chk("spurious", vec(PRI, 7), v);
    // level mode: a request dropped before acknowledge gives the spurious index
    init(PRI, 8'h19, 8'h08, 8'h04, 8'h01);
    @(negedge clk);
    irq[6] = 1'b1;
    for (int i = 0; i < 20 && intr !== 1'b1; i++) @(negedge clk);
    chk("intr_level", 1, {7'h00, intr});
    irq[6] = 1'b0;
    repeat (4) @(negedge clk);
    ack(v);
    chk("level_dropped", vec(PRI, 7), v);
    // single mode skips the cascade word, third odd write lands in the mask
    wr(PRI_EVEN_ADDR, 8'h13);
    wr(PRI_ODD_ADDR, 8'h08);
    wr(PRI_ODD_ADDR, 8'h01);
    wr(PRI_ODD_ADDR, 8'h5A);
    rd(PRI_ODD_ADDR, v);
    chk("single_mask", 8'h5A, v);
    results();
  end
endmodule : tb
